// ### common/serial_port_regs.svh
// Register indexes, field positions, reset values and timing counts
`ifndef SERIAL_PORT_REGS_SVH
`define SERIAL_PORT_REGS_SVH
// Register indexes; byte address is four times the index
`define SER0_CTL_IDX 8'h98
`define SER0_DATA_IDX 8'h99
`define IRQ_EN_IDX 8'ha8
`define SER1_DATA_IDX 8'hc1
`define SER1_CTL_IDX 8'hc0
`define PWR_CTL_IDX 8'h87
`define IRQ_STAT_IDX 8'he0
`define IRQ_MASK_IDX 8'he1
// Field positions
`define IE_GLOBAL 7
`define IE_SER1 6
`define IE_SER0 4
`define PWR_DBL 7
`define PWR_FES 6
`define PWR_T2 0
// Reset values
`define IE_RST 8'h00
`define MASK_RST 5'h00
// Timing counts in clock cycles or sample ticks
`define OSR_TOP 4'd15
`define START_MID 4'd7
`define M2_DIV 4'd4
`define M2_DIV_DBL 4'd2
`define M0_SLOW 4'd12
`define M0_FAST 4'd4
// Bus responses
`define RESP_OK 2'h0
`define RESP_SLVERR 2'h2
`endif

// ### common/serial_port_pkg.sv
// Types shared by the serial port control and status block
package serial_port_pkg;
   // Frame phase, Gray coded along idle-start-data-stop
   typedef enum logic [1:0] {
      PH_IDLE = 2'b00,
      PH_START = 2'b01,
      PH_DATA = 2'b11,
      PH_STOP = 2'b10
   } phase_t;
   // Register selected by a bus address
   typedef enum logic [3:0] {
      REG_NONE, REG_S0CTL, REG_S0DATA, REG_IE, REG_S1DATA,
      REG_S1CTL, REG_PWR, REG_ISTAT, REG_IMASK
   } reg_id_t;
   // Sticky interrupt events
   typedef struct packed {
      logic s1Ti;
      logic s1Ri;
      logic fe;
      logic ri;
      logic ti;
   } irq_ev_t;
   // Whole state of the block
   typedef struct packed {
      logic awHeld;
      logic wHeld;
      logic [11:0] awAddr;
      logic [7:0] wData;
      logic wLane;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [7:0] rdata;
      logic [1:0] mode;
      logic sm2;
      logic ren;
      logic tb8;
      logic rb8;
      logic ti;
      logic ri;
      logic fe;
      logic fes;
      logic dbl;
      logic t2sel;
      logic [7:0] ie;
      logic [7:0] rxBuf;
      logic [7:0] txBuf;
      logic txPend;
      logic [7:0] s1Tx;
      logic [7:0] s1Rx;
      logic s1Ri;
      logic s1Ti;
      logic s1Sm2;
      logic s1Load;
      irq_ev_t istat;
      irq_ev_t imask;
      logic irq;
      logic cpuIrq;
      logic [3:0] div;
      logic m0Act;
      logic m0Rx;
      logic m0Clk;
      logic [2:0] m0Cnt;
      logic [7:0] m0Sh;
      phase_t txPh;
      logic [3:0] txCnt;
      logic [3:0] txTick;
      logic [8:0] txSh;
      phase_t rxPh;
      logic [3:0] rxCnt;
      logic [3:0] rxTick;
      logic [8:0] rxSh;
      logic txdOut;
      logic rxdOut;
      logic rxdOeN;
   } state_t;
endpackage

// ### hw/serial_port_ctrl_status.sv
// Serial port control, status and data buffers behind an AXI4-Lite slave
`include "serial_port_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module serial_port_ctrl_status
   import serial_port_pkg::*;
#(
   parameter int AW = 12
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [AW-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [AW-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic rxdIn,
   output logic rxdOut,
   output logic rxdOeN,
   output logic txdOut,
   input wire logic timer1Tick,
   input wire logic timer2Tick,
   input wire logic powerFailIrq,
   input wire logic s1RxStrobe,
   input wire logic [7:0] s1RxByte,
   input wire logic s1RxNinth,
   input wire logic s1TxDone,
   output logic [7:0] s1TxByte,
   output logic s1TxLoad,
   output logic cpuIrq,
   output logic irq
);
   // Reset image of the whole state
   localparam state_t S_RST = '{txPh: PH_IDLE, rxPh: PH_IDLE,
      ie: `IE_RST, imask: `MASK_RST, txdOut: 1'b1, rxdOut: 1'b1,
      rxdOeN: 1'b1, default: '0};

   state_t s_r; // Registered state
   state_t s_nxt; // Next state
   logic [7:0] d; // Write data byte
   logic wrEn; // Write performed this cycle
   reg_id_t wrSel; // Register being written
   reg_id_t rdSel; // Register being read
   logic [3:0] top; // Divider wrap value
   logic aTick; // Async sample tick, 16 per bit
   logic m0Tick; // Mode 0 half-bit tick
   logic [3:0] last; // Index of last data bit
   logic stopSamp; // Mid-stop sample point
   logic rxLoad; // Received frame passes the filter
   irq_ev_t ev; // Events of this cycle

   // Address decode, shared by read and write
   function automatic reg_id_t regSel(input logic [AW-1:0] a);
      reg_id_t r;
      r = REG_NONE;
      if (a[1:0] == 2'h0 && (a >> 10) == '0) begin
         case (a[9:2])
            `SER0_CTL_IDX: r = REG_S0CTL;
            `SER0_DATA_IDX: r = REG_S0DATA;
            `IRQ_EN_IDX: r = REG_IE;
            `SER1_DATA_IDX: r = REG_S1DATA;
            `SER1_CTL_IDX: r = REG_S1CTL;
            `PWR_CTL_IDX: r = REG_PWR;
            `IRQ_STAT_IDX: r = REG_ISTAT;
            `IRQ_MASK_IDX: r = REG_IMASK;
            default: r = REG_NONE;
         endcase
      end
      return r;
   endfunction

   // Next-state logic for bus, registers and both frame engines
   always_comb begin
      s_nxt = s_r;
      ev = '0;
      d = s_r.wData;
      // Write address and data taken in either order
      if (awvalid && s_r.awready) begin
         s_nxt.awHeld = 1'b1;
         s_nxt.awAddr = 12'(awaddr);
      end
      if (wvalid && s_r.wready) begin
         s_nxt.wHeld = 1'b1;
         s_nxt.wData = wdata[7:0];
         s_nxt.wLane = wstrb[0];
      end
      if (s_r.bvalid && bready) begin
         s_nxt.bvalid = 1'b0;
      end
      wrEn = s_r.awHeld && s_r.wHeld && !s_r.bvalid;
      wrSel = regSel(AW'(s_r.awAddr));
      if (wrEn) begin
         s_nxt.awHeld = 1'b0;
         s_nxt.wHeld = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = (wrSel == REG_NONE) ? `RESP_SLVERR : `RESP_OK;
      end
      s_nxt.awready = !s_nxt.awHeld;
      s_nxt.wready = !s_nxt.wHeld;
      // Register writes; only byte lane 0 carries data
      s_nxt.s1Load = 1'b0;
      if (wrEn && s_r.wLane) begin
         case (wrSel)
            REG_S0CTL: begin
               if (s_r.fes) begin
                  // Bit 7 as frame error: writing 0 clears
                  if (!d[7]) s_nxt.fe = 1'b0;
               end else begin
                  s_nxt.mode[1] = d[7];
               end
               s_nxt.mode[0] = d[6];
               s_nxt.sm2 = d[5];
               s_nxt.ren = d[4];
               s_nxt.tb8 = d[3];
               s_nxt.rb8 = d[2];
               s_nxt.ti = d[1];
               s_nxt.ri = d[0];
            end
            REG_S0DATA: begin
               s_nxt.txBuf = d;
               s_nxt.txPend = 1'b1;
            end
            REG_IE: s_nxt.ie = d;
            REG_S1DATA: begin
               s_nxt.s1Tx = d;
               s_nxt.s1Load = 1'b1;
            end
            REG_S1CTL: begin
               s_nxt.s1Sm2 = d[2];
               s_nxt.s1Ti = d[1];
               s_nxt.s1Ri = d[0];
            end
            REG_PWR: begin
               s_nxt.dbl = d[`PWR_DBL];
               s_nxt.fes = d[`PWR_FES];
               s_nxt.t2sel = d[`PWR_T2];
            end
            REG_IMASK: s_nxt.imask = d[4:0];
            default: ;
         endcase
      end
      // Read channel; status clears on read, events below win
      if (s_r.rvalid && rready) begin
         s_nxt.rvalid = 1'b0;
      end
      rdSel = regSel(araddr);
      if (arvalid && s_r.arready) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp = (rdSel == REG_NONE) ? `RESP_SLVERR : `RESP_OK;
         case (rdSel)
            REG_S0CTL: s_nxt.rdata = {s_r.fes ? s_r.fe : s_r.mode[1],
               s_r.mode[0], s_r.sm2, s_r.ren, s_r.tb8, s_r.rb8,
               s_r.ti, s_r.ri};
            REG_S0DATA: s_nxt.rdata = s_r.rxBuf;
            REG_IE: s_nxt.rdata = s_r.ie;
            REG_S1DATA: s_nxt.rdata = s_r.s1Rx;
            REG_S1CTL: s_nxt.rdata = {5'h00, s_r.s1Sm2, s_r.s1Ti,
               s_r.s1Ri};
            REG_PWR: s_nxt.rdata = {s_r.dbl, s_r.fes, 5'h00, s_r.t2sel};
            REG_ISTAT: s_nxt.rdata = {3'h0, s_r.istat};
            REG_IMASK: s_nxt.rdata = {3'h0, s_r.imask};
            default: s_nxt.rdata = 8'h00;
         endcase
         if (rdSel == REG_ISTAT) s_nxt.istat = '0;
      end
      s_nxt.arready = !s_nxt.rvalid;
      // Prescaler: half bit in mode 0, sixteenth bit in mode 2
      if (s_r.mode == 2'b00) begin
         top = (s_r.sm2 ? `M0_FAST : `M0_SLOW) / 4'd2 - 4'd1;
      end else begin
         top = (s_r.dbl ? `M2_DIV_DBL : `M2_DIV) - 4'd1;
      end
      s_nxt.div = (s_r.div >= top) ? 4'd0 : s_r.div + 4'd1;
      m0Tick = (s_r.div >= top);
      // Variable rate takes timer 1 or timer 2 ticks
      if (s_r.mode == 2'b10) begin
         aTick = m0Tick;
      end else begin
         aTick = s_r.t2sel ? timer2Tick : timer1Tick;
      end
      last = s_r.mode[1] ? 4'd8 : 4'd7;
      stopSamp = 1'b0;
      rxLoad = 1'b0;
      // Mode 0: synchronous shift, device drives shift clock
      if (s_r.mode == 2'b00) begin
         if (!s_r.m0Act) begin
            if (s_r.txPend) begin
               s_nxt.m0Act = 1'b1;
               s_nxt.m0Rx = 1'b0;
               s_nxt.m0Sh = s_r.txBuf;
               s_nxt.txPend = 1'b0;
               s_nxt.m0Cnt = 3'd0;
            end else if (s_r.ren && !s_r.ri) begin
               s_nxt.m0Act = 1'b1;
               s_nxt.m0Rx = 1'b1;
               s_nxt.m0Cnt = 3'd0;
            end
         end else if (m0Tick) begin
            if (!s_r.m0Clk) begin
               // Rising clock: receiver samples data
               s_nxt.m0Clk = 1'b1;
               if (s_r.m0Rx) s_nxt.m0Sh = {rxdIn, s_r.m0Sh[7:1]};
            end else begin
               // Falling clock: next bit
               s_nxt.m0Clk = 1'b0;
               if (!s_r.m0Rx) s_nxt.m0Sh = {1'b1, s_r.m0Sh[7:1]};
               s_nxt.m0Cnt = s_r.m0Cnt + 3'd1;
               if (s_r.m0Cnt == 3'd7) begin
                  // End of 8th bit time
                  s_nxt.m0Act = 1'b0;
                  if (s_r.m0Rx) begin
                     s_nxt.rxBuf = s_r.m0Sh;
                     ev.ri = 1'b1;
                  end else begin
                     ev.ti = 1'b1;
                  end
               end
            end
         end
      end else begin
         // Async transmitter
         if (s_r.txPh == PH_IDLE) begin
            if (s_r.txPend) begin
               s_nxt.txPh = PH_START;
               s_nxt.txTick = 4'd0;
               s_nxt.txCnt = 4'd0;
               s_nxt.txSh = {s_r.tb8, s_r.txBuf};
               s_nxt.txPend = 1'b0;
            end
         end else if (aTick) begin
            s_nxt.txTick = s_r.txTick + 4'd1;
            if (s_r.txTick == `OSR_TOP) begin
               case (s_r.txPh)
                  PH_START: s_nxt.txPh = PH_DATA;
                  PH_DATA: begin
                     s_nxt.txSh = {1'b1, s_r.txSh[8:1]};
                     s_nxt.txCnt = s_r.txCnt + 4'd1;
                     if (s_r.txCnt == last) begin
                        s_nxt.txPh = PH_STOP;
                        ev.ti = 1'b1;
                     end
                  end
                  default: s_nxt.txPh = PH_IDLE;
               endcase
            end
         end
         // Async receiver
         if (s_r.rxPh == PH_IDLE) begin
            if (s_r.ren && !rxdIn) begin
               s_nxt.rxPh = PH_START;
               s_nxt.rxTick = 4'd0;
            end
         end else if (!s_r.ren) begin
            s_nxt.rxPh = PH_IDLE;
         end else if (aTick) begin
            s_nxt.rxTick = s_r.rxTick + 4'd1;
            case (s_r.rxPh)
               PH_START: begin
                  if (s_r.rxTick == `START_MID) begin
                     // Start must still be low at mid bit
                     s_nxt.rxPh = rxdIn ? PH_IDLE : PH_DATA;
                     s_nxt.rxTick = 4'd0;
                     s_nxt.rxCnt = 4'd0;
                  end
               end
               PH_DATA: begin
                  if (s_r.rxTick == `OSR_TOP) begin
                     s_nxt.rxSh = {rxdIn, s_r.rxSh[8:1]};
                     s_nxt.rxCnt = s_r.rxCnt + 4'd1;
                     if (s_r.rxCnt == last) s_nxt.rxPh = PH_STOP;
                  end
               end
               default: begin
                  if (s_r.rxTick == `OSR_TOP) begin
                     stopSamp = 1'b1;
                     s_nxt.rxPh = PH_IDLE;
                  end
               end
            endcase
         end
         // Mid-stop: filter, ninth-bit capture, frame error
         if (stopSamp) begin
            ev.fe = !rxdIn;
            if (s_r.mode == 2'b01) begin
               rxLoad = !s_r.sm2 || rxdIn;
            end else begin
               rxLoad = !s_r.sm2 || s_r.rxSh[8];
            end
            if (rxLoad && !s_r.ri) begin
               ev.ri = 1'b1;
               s_nxt.rxBuf = s_r.mode[1] ? s_r.rxSh[7:0] : s_r.rxSh[8:1];
               if (s_r.mode[1]) begin
                  s_nxt.rb8 = s_r.rxSh[8];
               end else if (!s_r.sm2) begin
                  s_nxt.rb8 = rxdIn;
               end
            end
         end
      end
      // Port 1 receive strobe with its own ninth-bit filter
      if (s1RxStrobe && !(s_r.s1Sm2 && !s1RxNinth)) begin
         s_nxt.s1Rx = s1RxByte;
         ev.s1Ri = 1'b1;
      end
      ev.s1Ti = s1TxDone;
      // Hardware sets win over software clears
      if (ev.ti) s_nxt.ti = 1'b1;
      if (ev.ri) s_nxt.ri = 1'b1;
      if (ev.fe) s_nxt.fe = 1'b1;
      if (ev.s1Ri) s_nxt.s1Ri = 1'b1;
      if (ev.s1Ti) s_nxt.s1Ti = 1'b1;
      s_nxt.istat = s_nxt.istat | ev;
      // Interrupt outputs
      s_nxt.irq = |(s_nxt.istat & s_nxt.imask);
      s_nxt.cpuIrq = powerFailIrq || (s_nxt.ie[`IE_GLOBAL] &&
         ((s_nxt.ie[`IE_SER0] && (s_nxt.ti || s_nxt.ri)) ||
         (s_nxt.ie[`IE_SER1] && (s_nxt.s1Ti || s_nxt.s1Ri))));
      // Pin drive: mode 0 clock on txd, data on rxd
      if (s_r.mode == 2'b00) begin
         s_nxt.txdOut = !s_nxt.m0Act || s_nxt.m0Clk;
         s_nxt.rxdOeN = !(s_nxt.m0Act && !s_nxt.m0Rx);
         s_nxt.rxdOut = s_nxt.rxdOeN || s_nxt.m0Sh[0];
      end else begin
         s_nxt.rxdOeN = 1'b1;
         s_nxt.rxdOut = 1'b1;
         case (s_nxt.txPh)
            PH_START: s_nxt.txdOut = 1'b0;
            PH_DATA: s_nxt.txdOut = s_nxt.txSh[0];
            default: s_nxt.txdOut = 1'b1;
         endcase
      end
   end

   // State register, synchronous reset
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_r <= S_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from the state register
   assign awready = s_r.awready;
   assign wready = s_r.wready;
   assign bvalid = s_r.bvalid;
   assign bresp = s_r.bresp;
   assign arready = s_r.arready;
   assign rvalid = s_r.rvalid;
   assign rresp = s_r.rresp;
   assign rdata = {24'h000000, s_r.rdata};
   assign rxdOut = s_r.rxdOut;
   assign rxdOeN = s_r.rxdOeN;
   assign txdOut = s_r.txdOut;
   assign s1TxByte = s_r.s1Tx;
   assign s1TxLoad = s_r.s1Load;
   assign cpuIrq = s_r.cpuIrq;
   assign irq = s_r.irq;

   // Checks on the frame engines and flags
   sequence seq_enter_stop;
      s_r.txPh == PH_DATA ##1 s_r.txPh == PH_STOP;
   endsequence
   sequence seq_m0_high;
      $rose(s_r.m0Clk) && s_r.m0Act && s_r.sm2;
   endsequence
   chk_fe_set: assert property (@(posedge clk) disable iff (!rst_n)
      stopSamp && !rxdIn |=> s_r.fe)
      else $error("frame error not set on bad stop");
   chk_fe_hold: assert property (@(posedge clk) disable iff (!rst_n)
      s_r.fe && !wrEn |=> s_r.fe)
      else $error("frame error lost without software clear");
   chk_ninth_filter: assert property (@(posedge clk)
      disable iff (!rst_n)
      stopSamp && s_r.mode[1] && s_r.sm2 && !s_r.rxSh[8] && !s_r.ri
      && !wrEn |=> !s_r.ri)
      else $error("receive done raised with ninth bit zero");
   chk_stop_filter: assert property (@(posedge clk)
      disable iff (!rst_n)
      stopSamp && s_r.mode == 2'b01 && s_r.sm2 && !rxdIn && !s_r.ri
      && !wrEn |=> !s_r.ri)
      else $error("receive done raised without stop bit");
   chk_m0_fast: assert property (@(posedge clk) disable iff (!rst_n)
      seq_m0_high ##0 s_r.mode == 2'b00
      |-> s_r.m0Clk ##1 s_r.m0Clk ##1 !s_r.m0Clk)
      else $error("fast shift clock half period wrong");
   chk_ren_gate: assert property (@(posedge clk) disable iff (!rst_n)
      s_r.rxPh == PH_IDLE && !s_r.ren |=> s_r.rxPh == PH_IDLE)
      else $error("reception started while disabled");
   chk_tx_ninth: assert property (@(posedge clk) disable iff (!rst_n)
      s_r.txPh == PH_IDLE ##1 s_r.txPh == PH_START
      |-> s_r.txSh[8] == $past(s_r.tb8))
      else $error("ninth transmit bit not taken from control");
   chk_ti_stop: assert property (@(posedge clk) disable iff (!rst_n)
      seq_enter_stop |-> s_r.ti && s_r.txdOut)
      else $error("transmit done missing at stop start");
   chk_ri_stop: assert property (@(posedge clk) disable iff (!rst_n)
      stopSamp && rxLoad && !s_r.ri |=> s_r.ri)
      else $error("receive done missing at mid stop");
   chk_s0_irq: assert property (@(posedge clk) disable iff (!rst_n)
      s_r.ie[`IE_GLOBAL] && s_r.ie[`IE_SER0] && s_r.ti |-> s_r.cpuIrq)
      else $error("port 0 request not raised");
   chk_global_mask: assert property (@(posedge clk)
      disable iff (!rst_n)
      !s_nxt.ie[`IE_GLOBAL] && !powerFailIrq |=> !s_r.cpuIrq)
      else $error("request raised while globally disabled");
endmodule
`default_nettype wire

// ### dv/serial_peer_model.sv
// Remote serial transceiver model on the far side of the link
`timescale 1ns/1ps
`default_nettype none
module serial_peer_model (
   input wire logic clk,
   input wire logic txd,
   input wire logic sclk,
   input wire logic sdat,
   output logic rxd
);
   // Async line idles at mark
   initial rxd = 1'b1;
   // Frame bits LSB first, bc clocks each, last one ln
   task automatic send(input logic [10:0] f, input int nb, input int bc,
         input int ln);
      for (int i = 0; i < nb; i++) begin
         @(posedge clk);
         rxd <= f[i];
         repeat (((i == nb - 1) ? ln : bc) - 1) @(posedge clk);
      end
      @(posedge clk);
      rxd <= 1'b1;
   endtask
   // Async frame caught mid bit, start bit first
   task automatic recv(output logic [10:0] f, input int nb, input int bc);
      int n;
      f = '0;
      n = 0;
      while (txd !== 1'b0 && n < 5000) begin
         @(posedge clk);
         n++;
      end
      repeat (bc / 2) @(posedge clk);
      for (int i = 0; i < nb; i++) begin
         f[i] = txd;
         if (i < nb - 1) repeat (bc) @(posedge clk);
      end
   endtask
   // Mode 0 data at shift clock rise; clocks per bit
   task automatic sync(output logic [7:0] d, output int per);
      int n;
      n = 0;
      for (int i = 0; i < 8; i++) begin
         while (sclk !== 1'b0 && n < 2000) begin
            @(posedge clk);
            n++;
         end
         while (sclk !== 1'b1 && n < 2000) begin
            @(posedge clk);
            n++;
         end
         d[i] = sdat;
         if (i == 0) per = n;
         if (i == 1) per = n - per;
      end
   endtask
endmodule
`default_nettype wire

// ### dv/tb_serial_port_ctrl_status.sv
// Self-checking bench for the serial port control and status block
`timescale 1ns/1ps
`default_nettype none
module tb_serial_port_ctrl_status;
   // Byte addresses
   localparam logic [11:0] adCtl = 12'h260;
   localparam logic [11:0] adDat = 12'h264;
   localparam logic [11:0] adIe = 12'h2a0;
   localparam logic [11:0] adS1d = 12'h304;
   localparam logic [11:0] adS1c = 12'h300;
   localparam logic [11:0] adPwr = 12'h21c;
   localparam logic [11:0] adIst = 12'h380;
   localparam logic [11:0] adImk = 12'h384;
   logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, rxdOut, rxdOeN;
   logic txdOut, timer1Tick, timer2Tick, powerFailIrq, s1RxStrobe;
   logic s1RxNinth, s1TxDone, s1TxLoad, cpuIrq, irq, peerRxd, t8;
   logic t1Off; // Silences timer 1 ticks
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, rs;
   logic [7:0] s1RxByte, s1TxByte, b, c, d0;
   logic [10:0] fr;
   int badCount, cmpCount, loadCnt, per;
   wire logic rxdLine;
   // Wire level: block drives only while its enable is low
   assign rxdLine = (rxdOeN === 1'b0) ? rxdOut : peerRxd;
   serial_port_ctrl_status dut (.clk, .rst_n, .awaddr, .awvalid,
      .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
      .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready, .rxdIn(rxdLine), .rxdOut, .rxdOeN, .txdOut, .timer1Tick,
      .timer2Tick, .powerFailIrq, .s1RxStrobe, .s1RxByte, .s1RxNinth,
      .s1TxDone, .s1TxByte, .s1TxLoad, .cpuIrq, .irq);
   serial_peer_model peer (.clk, .txd(txdOut), .sclk(txdOut),
      .sdat(rxdLine), .rxd(peerRxd));
   // Clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Rate ticks every other clock, 32 clocks per bit
   always @(posedge clk) begin
      timer1Tick <= ~timer1Tick & ~t1Off;
      timer2Tick <= ~timer2Tick;
      if (s1TxLoad === 1'b1) loadCnt <= loadCnt + 1;
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmpCount++;
      if (g !== e) begin
         badCount++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic reportAndStop;
      if (badCount == 0 && cmpCount > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Bus write; address and data offered together
   task automatic axw(input logic [11:0] a, input logic [7:0] d);
      int n;
      @(posedge clk);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (n > 200) badCount++;
         if (n > 200) reportAndStop();
      end while (bvalid !== 1'b1);
      rs = bresp;
      bready <= 1'b0;
   endtask
   // Bus read
   task automatic axr(input logic [11:0] a);
      int n;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
         if (arready) arvalid <= 1'b0;
         if (n > 200) badCount++;
         if (n > 200) reportAndStop();
      end while (rvalid !== 1'b1);
      rd = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask
   initial begin
      {rst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
      {timer1Tick, timer2Tick, powerFailIrq, s1RxStrobe, t1Off} = '0;
      {s1RxNinth, s1TxDone, awaddr, araddr, wdata, s1RxByte} = '0;
      wstrb = 4'hf;
      void'($urandom(47));
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      // Reset values, enable store, unmapped place
      axr(adCtl);
      chk(rd, 0);
      b = $urandom;
      axw(adIe, b);
      axr(adIe);
      chk(rd, b);
      axw(12'h010, 8'h5a);
      chk(rs, 2);
      axr(12'h010);
      chk({rd[29:0], rs}, 2);
      axw(adImk, 8'h01);
      axw(adIe, 8'h90);
      // Async transmit in modes 1 to 3
      for (int m = 1; m < 4; m++) begin
         b = $urandom;
         t8 = $urandom;
         c = {m[1:0], 2'b00, t8, 3'b000};
         axw(adCtl, c);
         fork
            axw(adDat, b);
            peer.recv(fr, (m == 1) ? 10 : 11, (m == 2) ? 64 : 32);
         join
         chk(fr, (m == 1) ? {2'b01, b, 1'b0} : {1'b1, t8, b, 1'b0});
         axr(adCtl);
         chk(rd, c | 8'h02);
      end
      // Interrupt outputs after transmit: status read clears irq, enables and power fail drive cpuIrq
      repeat (2) @(posedge clk);
      chk({irq, cpuIrq}, 3);
      axr(adIst);
      chk(rd, 1);
      repeat (2) @(posedge clk);
      chk(irq, 0);
      axw(adIe, 8'h10);
      repeat (2) @(posedge clk);
      chk(cpuIrq, 0);
      powerFailIrq <= 1'b1;
      repeat (3) @(posedge clk);
      chk(cpuIrq, 1);
      powerFailIrq <= 1'b0;
      // Mode 0 transmit at both shift rates
      for (int f = 0; f < 2; f++) begin
         b = $urandom;
         c = {2'b00, f[0], 5'h00};
         axw(adCtl, c);
         fork
            axw(adDat, b);
            peer.sync(d0, per);
         join
         chk(d0, b);
         chk(per, f ? 4 : 12);
         repeat (12) @(posedge clk);
         axr(adCtl);
         chk(rd, c | 8'h02);
      end
      // Mode 1 receive, then receiver off
      axw(adCtl, 8'h50);
      b = $urandom;
      peer.send({1'b1, b, 1'b0}, 10, 32, 32);
      axr(adDat);
      chk(rd, b);
      axr(adCtl);
      chk(rd, 8'h55);
      axw(adCtl, 8'h40);
      peer.send({1'b1, ~b, 1'b0}, 10, 32, 32);
      axr(adCtl);
      chk(rd & 8'hfb, 8'h40);
      axr(adDat);
      chk(rd, b);
      // Mode 3 address filter on the ninth bit
      for (int n9 = 0; n9 < 2; n9++) begin
         axw(adCtl, 8'hf0);
         peer.send({1'b1, n9[0], b, 1'b0}, 11, 32, 32);
         axr(adCtl);
         chk(rd & 8'hfb, n9 ? 8'hf1 : 8'hf0);
      end
      // Short low stop with filter on: error flag only
      axw(adCtl, 8'h70);
      axw(adPwr, 8'h40);
      peer.send({1'b0, b, 1'b0}, 10, 32, 24);
      axr(adCtl);
      chk(rd & 8'hf3, 8'hf0);
      axw(adCtl, 8'h70);
      axr(adCtl);
      chk(rd & 8'hf3, 8'h70);
      axw(adPwr, 8'h00);
      axr(adCtl);
      chk(rd & 8'hc0, 8'h40);
      // Double-rate mode 2, then mode 1 on timer 2 with timer 1 silent
      for (int k = 0; k < 2; k++) begin
         b = $urandom;
         t1Off <= k[0];
         axw(adPwr, k ? 8'h01 : 8'h80);
         axw(adCtl, k ? 8'h40 : 8'h88);
         fork
            axw(adDat, b);
            peer.recv(fr, k ? 10 : 11, 32);
         join
         chk(fr, k ? {2'b01, b, 1'b0} : {2'b11, b, 1'b0});
      end
      t1Off <= 1'b0;
      // Port 1 buffers and enable
      axw(adIe, 8'hc0);
      @(posedge clk);
      s1RxByte <= b;
      s1RxStrobe <= 1'b1;
      @(posedge clk);
      s1RxStrobe <= 1'b0;
      axr(adS1d);
      chk(rd, b);
      chk(cpuIrq, 1);
      axw(adIe, 8'h80);
      repeat (2) @(posedge clk);
      chk(cpuIrq, 0);
      // Port 1 filter drops a byte with ninth bit zero
      axw(adS1c, 8'h04);
      @(posedge clk);
      s1RxByte <= ~b;
      s1RxNinth <= 1'b0;
      s1RxStrobe <= 1'b1;
      @(posedge clk);
      s1RxStrobe <= 1'b0;
      s1TxDone <= 1'b1;
      @(posedge clk);
      s1TxDone <= 1'b0;
      axr(adS1d);
      chk(rd, b);
      axr(adS1c);
      chk(rd, 8'h06);
      // Every event since the last status read is held
      axr(adIst);
      chk(rd, 8'h1f);
      b = $urandom;
      axw(adS1d, b);
      repeat (2) @(posedge clk);
      chk({loadCnt[7:0], s1TxByte}, {8'h01, b});
      reportAndStop();
   end
endmodule
`default_nettype wire
